//--- rtc_shift_cal_map.vh
// Register map, field positions and reset values of the sub-second, shift and calibration block
`ifndef RTC_SHIFT_CAL_MAP_VH
`define RTC_SHIFT_CAL_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_PROTECTION_KEY     8'h24
`define OFS_SUBSECOND_VALUE    8'h28
`define OFS_SHIFT_CONTROL      8'h2C
`define OFS_STAMP_TIME         8'h30
`define OFS_STAMP_DATE         8'h34
`define OFS_STAMP_SUBSECOND    8'h38
`define OFS_SMOOTH_CALIBRATION 8'h3C
`define OFS_BLOCK_STATUS       8'h60
`define OFS_BLOCK_CONTROL      8'h64

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_ADD_ONE_SECOND     31
`define BIT_PULSE_INSERT       15
`define BIT_CYCLE_8S           14
`define BIT_CYCLE_16S          13
`define BIT_ST_SHIFT_PENDING   0
`define BIT_ST_SYNCED          1
`define BIT_ST_TIMESTAMP       2
`define BIT_ST_UNLOCKED        3
`define BIT_CT_SHADOW_BYPASS   0
`define MASK_STAMP_TIME        32'h007F_7F7F
`define MASK_STAMP_DATE        32'h0000_FF3F

// ---------------------------------------------------------------
// Reset values and key codes (key codes are arbitrary)
// ---------------------------------------------------------------
`define RST_WORD               32'h0000_0000
`define RST_CALIBRATION_MINUS               9'h000
`define KEY_FIRST              8'hA5
`define KEY_SECOND             8'h5A
`define ASYNC_DIV_DEFAULT      7'h7F

`endif

//--- rtc_shift_cal.v
// Sub-second readout, atomic shift, timestamp capture and smooth calibration with an AHB-Lite slave
`include "rtc_shift_cal_map.vh"

module rtc_shift_cal #(
    parameter ASYNC_DIV = `ASYNC_DIV_DEFAULT
) (
    // Clock and resets
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        sys_rst_n_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [11:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    // Calendar side
    input  wire [14:0] prescaler_sync_factor_i,
    input  wire [31:0] calendar_time_i,
    input  wire [31:0] calendar_date_i,
    input  wire        stamp_event_i,
    output reg         second_tick_o
);

    // ---------------------------------------------------------------
    // Local states and declarations
    // ---------------------------------------------------------------
    localparam [1:0] LOCKED = 2'd0;
    localparam [1:0] HALF   = 2'd1;
    localparam [1:0] OPEN   = 2'd2;
    reg        rst_q1;
    reg        rst_n;
    reg        sys_q1;
    reg        sys_q2;
    reg        ev_q1;
    reg        ev_q2;
    reg        ev_q3;
    reg [1:0]  lock;
    reg [1:0]  next_lock;
    reg        dp_wr;
    reg [7:0]  dp_addr;
    reg        shift_pending_flag;
    reg        add_one_second;
    reg [14:0] fraction_subtract;
    reg        registers_synced_flag;
    reg        shadow_bypass;
    reg [15:0] ss_count;
    reg [15:0] ss_shadow;
    reg [6:0]  async_count;
    reg [19:0] cal_count;
    reg        pulse_insert_enable;
    reg        cycle_8s_select;
    reg        cycle_16s_select;
    reg [8:0]  calibration_minus_raw;
    reg        timestamp_flag;
    reg [31:0] stamp_time;
    reg [31:0] stamp_date;
    reg [15:0] stamp_subsecond;
    wire        addr_valid;
    wire        unlocked;
    wire        wr_key;
    wire        wr_shift;
    wire        wr_cal;
    wire        wr_status;
    wire        wr_ctrl;
    wire        shift_accept;
    wire        stamp_event;
    wire [8:0]  calibration_minus;
    wire        slot_start;
    wire        mask_pulse;
    wire        insert_pulse;
    wire [7:0]  async_sum;
    wire        apre_tick;
    wire        apply_shift;
    wire [15:0] subsecond_view;
    wire [31:0] read_word;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Register hit on a word offset
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    // Slot is among the first n slots of the 2^20 window, first n/4 of 2^18 in 8 s mode, first n/2 of 2^19 in 16 s mode
    function slot_masked;
        input [19:0] cnt;
        input [8:0]  n;
        input        w8;
        input        w16;
        begin
            if (w8) begin
                slot_masked = ({2'b00, cnt[17:11]} < {2'b00, n[8:2]});
            end else if (w16) begin
                slot_masked = ({1'b0, cnt[18:11]} < {1'b0, n[8:1]});
            end else begin
                slot_masked = (cnt[19:11] < n);
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // Reset and pin synchronisers
    // ---------------------------------------------------------------
    // Backup-domain reset release
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // System reset and timestamp pin synchronisers
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sys_q1 <= 1'b0;
            sys_q2 <= 1'b0;
            ev_q1  <= 1'b0;
            ev_q2  <= 1'b0;
            ev_q3  <= 1'b0;
        end else begin
            sys_q1 <= sys_rst_n_i;
            sys_q2 <= sys_q1;
            ev_q1  <= stamp_event_i;
            ev_q2  <= ev_q1;
            ev_q3  <= ev_q2;
        end
    end

    assign stamp_event = ev_q2 & ~ev_q3;
    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign addr_valid  = hsel_i & htrans_i[1] & hready_i;
    // Address phase capture and registered read data
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr    <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata_o <= `RST_WORD;
        end else begin
            dp_wr    <= addr_valid & hwrite_i;
            dp_addr  <= haddr_i[7:0];
            if (addr_valid & ~hwrite_i) begin
                hrdata_o <= read_word;
            end else begin
                hrdata_o <= `RST_WORD;
            end
        end
    end

    assign wr_key    = dp_wr & hit(dp_addr, `OFS_PROTECTION_KEY);
    assign wr_shift  = dp_wr & hit(dp_addr, `OFS_SHIFT_CONTROL);
    assign wr_cal    = dp_wr & hit(dp_addr, `OFS_SMOOTH_CALIBRATION);
    assign wr_status = dp_wr & hit(dp_addr, `OFS_BLOCK_STATUS);
    assign wr_ctrl   = dp_wr & hit(dp_addr, `OFS_BLOCK_CONTROL);
    assign unlocked  = (lock == OPEN);
    // Read multiplexer, key and shift fields read zero
    // key reads zero
    assign read_word =
        hit(haddr_i[7:0], `OFS_SUBSECOND_VALUE)    ? {16'h0000, subsecond_view} :
        hit(haddr_i[7:0], `OFS_STAMP_TIME)         ? stamp_time :
        hit(haddr_i[7:0], `OFS_STAMP_DATE)         ? stamp_date :
        hit(haddr_i[7:0], `OFS_STAMP_SUBSECOND)    ? {16'h0000, stamp_subsecond} :
        hit(haddr_i[7:0], `OFS_SMOOTH_CALIBRATION) ? {16'h0000, pulse_insert_enable,
                                                      cycle_8s_select, cycle_16s_select,
                                                      4'h0, calibration_minus} :
        hit(haddr_i[7:0], `OFS_BLOCK_STATUS)       ? {28'h000_0000, unlocked, timestamp_flag,
                                                      registers_synced_flag,
                                                      shift_pending_flag} :
        hit(haddr_i[7:0], `OFS_BLOCK_CONTROL)      ? {31'h0000_0000, shadow_bypass} :
        `RST_WORD;

    // ---------------------------------------------------------------
    // Write protection
    // ---------------------------------------------------------------
    // key sequence unlock
    always @* begin
        next_lock = lock;
        if (wr_key) begin
            case (lock)
                LOCKED: next_lock = (hwdata_i[7:0] == `KEY_FIRST) ? HALF : LOCKED;
                HALF:   next_lock = (hwdata_i[7:0] == `KEY_SECOND) ? OPEN : LOCKED;
                OPEN:   next_lock = LOCKED;
                default: next_lock = LOCKED;
            endcase
        end
    end

    // Protection state, wrong key relocks
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            lock <= LOCKED;
        end else begin
            lock <= next_lock;
        end
    end

    // ---------------------------------------------------------------
    // Shift control
    // ---------------------------------------------------------------
    // ignore while pending
    assign shift_accept = wr_shift & unlocked & ~shift_pending_flag;
    assign apply_shift  = shift_pending_flag & ~apre_tick;
    // Pending flag, latched shift request and synced flag
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_pending_flag    <= 1'b0;
            add_one_second        <= 1'b0;
            fraction_subtract     <= 15'h0000;
            registers_synced_flag <= 1'b0;
        end else begin
            if (shift_accept) begin
                shift_pending_flag <= 1'b1;
                add_one_second     <= hwdata_i[`BIT_ADD_ONE_SECOND];
                fraction_subtract  <= hwdata_i[14:0];
            end else if (apply_shift) begin
                shift_pending_flag <= 1'b0;
            end
            registers_synced_flag <= ~shift_accept & ~shift_pending_flag;
        end
    end

    // ---------------------------------------------------------------
    // Smooth calibration
    // ---------------------------------------------------------------
    // Calibration register, protected
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pulse_insert_enable <= 1'b0;
            cycle_8s_select     <= 1'b0;
            cycle_16s_select    <= 1'b0;
            calibration_minus_raw            <= `RST_CALIBRATION_MINUS;
        end else if (wr_cal & unlocked) begin
            pulse_insert_enable <= hwdata_i[`BIT_PULSE_INSERT];
            cycle_8s_select     <= hwdata_i[`BIT_CYCLE_8S];
            cycle_16s_select    <= hwdata_i[`BIT_CYCLE_16S];
            calibration_minus_raw            <= hwdata_i[8:0];
        end
    end

    assign calibration_minus = {calibration_minus_raw[8:2],
                                calibration_minus_raw[1] & ~cycle_8s_select,
                                calibration_minus_raw[0] & ~cycle_8s_select & ~cycle_16s_select};
    // Kernel pulse window counter
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cal_count <= 20'h0_0000;
        end else begin
            cal_count <= cal_count + 20'h0_0001;
        end
    end

    assign slot_start   = (cal_count[10:0] == 11'h000);
    assign mask_pulse   = slot_start & slot_masked(cal_count, calibration_minus,
                                                   cycle_8s_select, cycle_16s_select);
    assign insert_pulse = slot_start & pulse_insert_enable;
    // Asynchronous prescaler step: 0, 1 or 3 kernel pulses
    assign async_sum = {1'b0, async_count} + {6'h00, insert_pulse & ~mask_pulse,
                                              ~(mask_pulse & ~insert_pulse)};
    assign apre_tick = (async_sum > {1'b0, ASYNC_DIV[6:0]});
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            async_count <= 7'h00;
        end else if (apre_tick) begin
            async_count <= async_sum[6:0] - ASYNC_DIV[6:0] - 7'h01;
        end else begin
            async_count <= async_sum[6:0];
        end
    end

    // ---------------------------------------------------------------
    // Synchronous prescaler and sub-second view
    // ---------------------------------------------------------------
    // Down counter, reload and shift apply
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ss_count      <= 16'h0000;
            second_tick_o <= 1'b0;
        end else begin
            second_tick_o <= 1'b0;
            if (apre_tick) begin
                if (ss_count == 16'h0000) begin
                    ss_count      <= {1'b0, prescaler_sync_factor_i};
                    second_tick_o <= 1'b1;
                end else begin
                    ss_count <= ss_count - 16'h0001;
                end
            end else if (apply_shift) begin
                ss_count      <= ss_count + {1'b0, fraction_subtract};
                second_tick_o <= add_one_second;
            end
        end
    end

    // Shadow copy, system reset clears it unless bypassed
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ss_shadow <= 16'h0000;
        end else if (~sys_q2 & ~shadow_bypass) begin
            ss_shadow <= 16'h0000;
        end else if (sys_q2) begin
            ss_shadow <= ss_count;
        end
    end

    assign subsecond_view = shadow_bypass ? ss_count : ss_shadow;
    // Shadow bypass control, backup domain
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            shadow_bypass <= 1'b0;
        end else if (wr_ctrl) begin
            shadow_bypass <= hwdata_i[`BIT_CT_SHADOW_BYPASS];
        end
    end

    // ---------------------------------------------------------------
    // Timestamp capture
    // ---------------------------------------------------------------
    // First event wins, set beats clear
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            timestamp_flag  <= 1'b0;
            stamp_time      <= `RST_WORD;
            stamp_date      <= `RST_WORD;
            stamp_subsecond <= 16'h0000;
        end else if (stamp_event & ~timestamp_flag) begin
            timestamp_flag  <= 1'b1;
            stamp_time      <= calendar_time_i & `MASK_STAMP_TIME;
            stamp_date      <= calendar_date_i & `MASK_STAMP_DATE;
            stamp_subsecond <= ss_count;
        end else if (wr_status & hwdata_i[`BIT_ST_TIMESTAMP] & ~stamp_event) begin
            timestamp_flag  <= 1'b0;
            stamp_time      <= `RST_WORD;
            stamp_date      <= `RST_WORD;
            stamp_subsecond <= 16'h0000;
        end
    end

endmodule

//--- rtc_shift_cal_monitor.sv
// Port-level assertions for the sub-second, shift, timestamp and calibration block
`include "rtc_shift_cal_map.vh"
module rtc_shift_cal_monitor (
    // Clock and resets
    input wire        clock_i,
    input wire        rst_n_i,
    input wire        sys_rst_n_i,
    // Register bus
    input wire        hsel_i,
    input wire [11:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [2:0]  hsize_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire [31:0] hrdata_o,
    input wire        hreadyout_o,
    input wire        hresp_o,
    // Calendar side
    input wire [14:0] prescaler_sync_factor_i,
    input wire [31:0] calendar_time_i,
    input wire [31:0] calendar_date_i,
    input wire        stamp_event_i,
    input wire        second_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rd_q;
    logic       wr_q;
    logic [7:0] addr_q;
    logic       key_half;
    logic       unlocked;
    // Data phase tracking and a copy of the key sequence state
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q     <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= 8'h00;
            key_half <= 1'b0;
            unlocked <= 1'b0;
        end else begin
            rd_q   <= hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
            wr_q   <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            addr_q <= haddr_i[7:0];
            if (wr_q && addr_q == `OFS_PROTECTION_KEY) begin
                key_half <= !unlocked && !key_half && hwdata_i[7:0] == `KEY_FIRST;
                unlocked <= !unlocked && key_half && hwdata_i[7:0] == `KEY_SECOND;
            end
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence add_second_write;
        wr_q && addr_q == `OFS_SHIFT_CONTROL && hwdata_i[`BIT_ADD_ONE_SECOND] && unlocked;
    endsequence
    sequence tick_follows;
        ##[1:6] second_tick_o;
    endsequence
    ready_high_a : assert property (hreadyout_o == 1'b1)
        else $error("ready output dropped");
    resp_okay_a : assert property (hresp_o == 1'b0)
        else $error("error response seen");
    idle_data_zero_a : assert property (!rd_q |-> hrdata_o == 32'h0000_0000)
        else $error("read data outside a read data phase");
    key_reads_zero_a : assert property (
        rd_q && addr_q == `OFS_PROTECTION_KEY |-> hrdata_o == 32'h0000_0000) else $error("key read not zero");
    shift_reads_zero_a : assert property (
        rd_q && addr_q == `OFS_SHIFT_CONTROL |-> hrdata_o == 32'h0000_0000) else $error("shift read not zero");
    subsec_width_a : assert property (
        rd_q && (addr_q == `OFS_SUBSECOND_VALUE || addr_q == `OFS_STAMP_SUBSECOND) |-> hrdata_o[31:16] == 16'h0000)
        else $error("sub-second upper half not zero");
    stamp_time_mask_a : assert property (
        rd_q && addr_q == `OFS_STAMP_TIME |-> (hrdata_o & ~`MASK_STAMP_TIME) == 32'h0000_0000)
        else $error("stamp time reserved bits set");
    stamp_date_mask_a : assert property (
        rd_q && addr_q == `OFS_STAMP_DATE |-> (hrdata_o & ~`MASK_STAMP_DATE) == 32'h0000_0000)
        else $error("stamp date reserved bits set");
    cal_forced_bits_a : assert property (
        rd_q && addr_q == `OFS_SMOOTH_CALIBRATION |-> hrdata_o[31:16] == 16'h0000 && hrdata_o[12:9] == 4'h0
        && (!hrdata_o[14] || hrdata_o[1:0] == 2'b00) && (!hrdata_o[13] || !hrdata_o[0]))
        else $error("calibration forced bits wrong");
    add_second_tick_a : assert property (add_second_write |-> tick_follows)
        else $error("no second tick after accepted shift");
endmodule

bind rtc_shift_cal rtc_shift_cal_monitor rtc_shift_cal_monitor_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .prescaler_sync_factor_i(prescaler_sync_factor_i), .calendar_time_i(calendar_time_i),
    .calendar_date_i(calendar_date_i), .stamp_event_i(stamp_event_i), .second_tick_o(second_tick_o));

//--- rtc_shift_cal_tb.sv
// Self-checking bench for the sub-second, shift, timestamp and calibration block
`include "rtc_shift_cal_map.vh"
module rtc_shift_cal_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, rst_n_i, sys_rst_n_i, hsel_i, hwrite_i, stamp_event_i;
    logic [11:0] haddr_i;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i, calendar_time_i, calendar_date_i, ss_a, ss_b;
    logic [14:0] prescaler_sync_factor_i;
    wire  [31:0] hrdata_o;
    wire         hreadyout_o, hresp_o, second_tick_o;
    int          num_errors = 0;
    int          checks_done = 0;
    int          ticks = 0;
    int          n;
    logic [7:0]  reset_ofs [6] = '{`OFS_PROTECTION_KEY, `OFS_SHIFT_CONTROL, `OFS_STAMP_TIME, `OFS_STAMP_DATE,
                                   `OFS_STAMP_SUBSECOND, `OFS_SMOOTH_CALIBRATION};
    logic [31:0] cal_wr [4] = '{32'h0000_81FF, 32'h0000_41FF, 32'h0000_21FF, 32'hFFFF_1E03};
    logic [31:0] cal_rd [4] = '{32'h0000_81FF, 32'h0000_41FC, 32'h0000_21FE, 32'h0000_0003};

    rtc_shift_cal #(.ASYNC_DIV(3)) rtc_shift_cal_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .prescaler_sync_factor_i(prescaler_sync_factor_i), .calendar_time_i(calendar_time_i),
        .calendar_date_i(calendar_date_i), .stamp_event_i(stamp_event_i), .second_tick_o(second_tick_o));

    // ---------------------------------------------------------------
    // Clock, tick counter and watchdog
    // ---------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (second_tick_o === 1'b1) ticks <= ticks + 1;
    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        end_sim;
    end

    // ---------------------------------------------------------------
    // Compare, bus and closing tasks
    // ---------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // One single word transfer, held until ready is seen at each phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i  <= {4'h0, a};
        hwrite_i <= wr;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        rd = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, d);
        cmp(d & m, exp);
    endtask
    task automatic unlock;
        wr(`OFS_PROTECTION_KEY, {24'h00_0000, `KEY_FIRST});
        wr(`OFS_PROTECTION_KEY, {24'h00_0000, `KEY_SECOND});
    endtask
    task automatic end_sim;
        $display("checks done %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        {rst_n_i, hsel_i, hwrite_i, stamp_event_i, haddr_i, htrans_i, hwdata_i} = '0;
        {calendar_time_i, calendar_date_i} = '0;
        sys_rst_n_i = 1'b1;
        hsize_i = 3'b010;
        prescaler_sync_factor_i = 15'h7FFF;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        // Reset values, unmapped word and key readback
        foreach (reset_ofs[i]) rd_cmp(reset_ofs[i], 32'hFFFF_FFFF, `RST_WORD);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_cmp(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`OFS_PROTECTION_KEY, {24'h00_0000, `KEY_FIRST});
        rd_cmp(`OFS_PROTECTION_KEY, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`OFS_PROTECTION_KEY, {24'h00_0000, `KEY_SECOND});
        rd_cmp(`OFS_BLOCK_STATUS, 32'h0000_0008, 32'h0000_0008);
        // Calibration modes and forced bits
        foreach (cal_wr[i]) begin
            wr(`OFS_SMOOTH_CALIBRATION, cal_wr[i]);
            rd_cmp(`OFS_SMOOTH_CALIBRATION, 32'hFFFF_FFFF, cal_rd[i]);
        end
        // Locked: calibration and shift writes dropped, then shift with add one second applied once unlocked
        wr(`OFS_PROTECTION_KEY, 32'h0000_0000);
        wr(`OFS_SMOOTH_CALIBRATION, 32'h0000_8155);
        rd_cmp(`OFS_SMOOTH_CALIBRATION, 32'hFFFF_FFFF, 32'h0000_0003);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) unlock;
            bus(1'b0, `OFS_SUBSECOND_VALUE, 32'h0000_0000, ss_a);
            n = ticks;
            wr(`OFS_SHIFT_CONTROL, 32'h8000_7000);
            rd_cmp(`OFS_BLOCK_STATUS, 32'h0000_0002, (k == 0) ? 32'h0000_0002 : 32'h0000_0000);
            repeat (10) @(posedge clock_i);
            bus(1'b0, `OFS_SUBSECOND_VALUE, 32'h0000_0000, ss_b);
            if (k == 1) ss_a = ss_a + 32'h0000_7000;
            cmp(ticks, n + k);
            cmp_rng(ss_b, ss_a - 32'h0000_0010, ss_a);
        end
        cmp_rng(ss_b, 32'h0000_8000, 32'h0000_FFFF);
        rd_cmp(`OFS_BLOCK_STATUS, 32'h0000_0003, 32'h0000_0002);
        // System reset with shadow bypass off, then on
        sys_rst_n_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        rd_cmp(`OFS_SUBSECOND_VALUE, 32'hFFFF_FFFF, 32'h0000_0000);
        sys_rst_n_i <= 1'b1;
        wr(`OFS_BLOCK_CONTROL, 32'h0000_0001);
        sys_rst_n_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        bus(1'b0, `OFS_SUBSECOND_VALUE, 32'h0000_0000, ss_a);
        cmp_rng(ss_a, 32'h0000_0001, 32'h0000_FFFF);
        sys_rst_n_i <= 1'b1;
        // Timestamp capture and clear
        calendar_time_i <= 32'hFFFF_FFFF;
        calendar_date_i <= 32'hFFFF_FFFF;
        stamp_event_i   <= 1'b1;
        repeat (4) @(posedge clock_i);
        stamp_event_i   <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd_cmp(`OFS_BLOCK_STATUS, 32'h0000_0004, 32'h0000_0004);
        rd_cmp(`OFS_STAMP_TIME, 32'hFFFF_FFFF, `MASK_STAMP_TIME);
        rd_cmp(`OFS_STAMP_DATE, 32'hFFFF_FFFF, `MASK_STAMP_DATE);
        bus(1'b0, `OFS_STAMP_SUBSECOND, 32'h0000_0000, ss_b);
        cmp_rng(ss_b, ss_a - 32'h0000_0020, ss_a - 32'h0000_0001);
        wr(`OFS_BLOCK_STATUS, 32'h0000_0004);
        rd_cmp(`OFS_BLOCK_STATUS, 32'h0000_0004, 32'h0000_0000);
        for (int k = 2; k < 5; k++) rd_cmp(reset_ofs[k], 32'hFFFF_FFFF, 32'h0000_0000);
        end_sim;
    end
endmodule
